// file: hw/ugi_top.sv
// Purpose: usb global event flags, enables, combined interrupt and endpoint index select
// Assumes: event pulses come from logic on pclk; bus idle level comes from a pin
// Notes: registers reached over apb, one aligned word each, byte address = index * 4
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

// Behaviour
// R1: unused bits of the flag, enable and endpoint index registers read as zero and ignore writes.
// R2: while suspended, non-idle bus signalling sets the wake flag in bit 5, an own upstream resume does not.
// R3: firmware clears the wake flag only after it has re-enabled all usb clocks.
// R4: end of bus reset sets the end-of-reset flag in bit 4, which stays until software clears it.
// R5: each error-free start-of-frame packet sets the frame flag in bit 3, which stays until cleared.
// R6: three frame periods of idle j state set the suspend flag in bit 0, which stays until cleared.
// R7: the usb interrupt is requested while any flag is set together with its enable in the same position.
// R8: after reset only the end-of-reset enable is set.
// R9: after reset the flag register and the endpoint index register are zero.
// R10: the 2-bit endpoint index selects which endpoint's per-endpoint registers are reached.
// R11: bit 7 of the indexed endpoint control register enables the selected endpoint.
// R12: after every hardware and bus reset firmware enables endpoint 0.
// R13: the combined interrupt reaches the core only while the core usb interrupt enable is set.
// R14: the read-only toggle bit 3 of the indexed control register is set on data1 and cleared on data0.
// R15: writing zero clears a flag, writing one leaves it, and a set in the same cycle wins.
module ugi_top
   import ugi_pkg::*;
#(
   parameter int SUSPEND_IDLE_CYCLES = SUSPEND_CYCLES
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  bus_idle_j,
   input  wire ugi_pkg::ugi_evt_s     evt,
   input  wire logic [EP_IDX_W-1:0]   rx_ep,
   output logic                       usb_irq,
   output logic                       usb_irq_to_core,
   output logic [NUM_EP-1:0]          endpoint_on,
   output logic [EP_IDX_W-1:0]        endpoint_index
);
   import ugi_pkg::*;

   logic [7:0]        flags_r;
   logic [7:0]        enables_r;
   logic [7:0]        ep_sel_r;
   logic [7:0]        ep_ctrl_r [NUM_EP];
   logic              core_irq_en_r;
   logic              idle_j_s;
   logic              suspend_pulse;
   logic              suspended;
   logic              wr_acc;
   logic              rd_acc;
   logic [9:0]        widx;
   logic              addr_ok;
   logic [7:0]        wbyte;
   logic [7:0]        set_vec;
   logic [7:0]        rd_byte;
   logic [7:0]        flags_nxt;
   logic [EP_IDX_W-1:0] sel;

   // pin level crosses into pclk before anything looks at it
   ugi_sync #(
      .W (1)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (bus_idle_j),
      .q       (idle_j_s)
   );

   ugi_suspend_det #(
      .IDLE_CYCLES (SUSPEND_IDLE_CYCLES)
   ) u_susp (
      .pclk          (pclk),
      .presetn       (presetn),
      .idle_j        (idle_j_s),
      .suspend_pulse (suspend_pulse), // R6
      .suspended     (suspended)
   );

   // apb decode; word-aligned, unmapped or misaligned gives pslverr
   assign widx    = paddr[ADDR_W-1:2];
   assign addr_ok = (paddr[1:0] == 2'b00) &&
                    (widx == IDX_EVENT_FLAGS || widx == IDX_EVENT_ENA ||
                     widx == IDX_EP_SELECT || widx == IDX_EP_CONTROL || widx == IDX_CORE_IRQ);
   assign wr_acc  = psel && penable && pready && pwrite && addr_ok && pstrb[0];
   assign rd_acc  = psel && penable && pready && !pwrite;
   assign wbyte   = pwdata[7:0];
   assign sel     = ep_sel_r[EP_IDX_W-1:0]; // R10

   // hardware set sources for the flag register
   always_comb begin
      set_vec               = 8'h00;
      set_vec[BIT_SUSPEND]  = suspend_pulse;                                  // R6
      set_vec[BIT_FRAME]    = evt.frame_ok;                                   // R5
      set_vec[BIT_END_RESET]= evt.reset_end;                                  // R4
      set_vec[BIT_WAKE_CPU] = suspended && evt.non_idle && !evt.upstream_resume; // R2
   end

   // write zero clears, write one keeps, set beats clear
   always_comb begin
      flags_nxt = flags_r;
      if (wr_acc && widx == IDX_EVENT_FLAGS) begin
         flags_nxt = flags_r & wbyte; // R15
      end
      flags_nxt = (flags_nxt | set_vec) & FLAG_MASK; // R1
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= FLAGS_RESET; // R9
      end else begin
         flags_r <= flags_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enables_r     <= ENA_RESET; // R8
         ep_sel_r      <= EP_SEL_RESET; // R9
         core_irq_en_r <= 1'b0;
      end else if (wr_acc) begin
         if (widx == IDX_EVENT_ENA) begin
            enables_r <= wbyte & FLAG_MASK; // R1
         end
         if (widx == IDX_EP_SELECT) begin
            ep_sel_r <= wbyte & EP_SEL_MASK; // R1
         end
         if (widx == IDX_CORE_IRQ) begin
            core_irq_en_r <= wbyte[BIT_CORE_IRQ_EN];
         end
      end
   end

   // per-endpoint control; toggle bit follows received data pid
   generate
      for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ep_ctrl_r[e] <= EP_CTRL_RESET;
            end else begin
               if (wr_acc && widx == IDX_EP_CONTROL && sel == EP_IDX_W'(e)) begin
                  ep_ctrl_r[e] <= (wbyte & EP_CTRL_WR_MASK) |
                                  (ep_ctrl_r[e] & ~EP_CTRL_WR_MASK); // R10
               end
               if (rx_ep == EP_IDX_W'(e) && evt.data1_rx) begin
                  ep_ctrl_r[e][BIT_TOGGLE] <= 1'b1; // R14
               end else if (rx_ep == EP_IDX_W'(e) && evt.data0_rx) begin
                  ep_ctrl_r[e][BIT_TOGGLE] <= 1'b0; // R14
               end
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               endpoint_on[e] <= 1'b0;
            end else begin
               endpoint_on[e] <= ep_ctrl_r[e][BIT_EP_ON]; // R11
            end
         end
      end
   endgenerate

   always_comb begin
      rd_byte = 8'h00;
      unique case (widx)
         IDX_EVENT_FLAGS: rd_byte = flags_r;
         IDX_EVENT_ENA:   rd_byte = enables_r;
         IDX_EP_SELECT:   rd_byte = ep_sel_r;
         IDX_EP_CONTROL:  rd_byte = ep_ctrl_r[sel]; // R10
         IDX_CORE_IRQ:    rd_byte = {7'h00, core_irq_en_r};
         default:         rd_byte = 8'h00;
      endcase
   end

   // no wait state: setup, then access answered in its first cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable && !pwrite) begin
            // a refused read must not leak the register its word index happens to hit
            prdata <= addr_ok ? {24'h0, rd_byte} : 32'h0;
         end else if (rd_acc) begin
            prdata <= 32'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_irq         <= 1'b0;
         usb_irq_to_core <= 1'b0;
         endpoint_index  <= '0;
      end else begin
         usb_irq         <= |(flags_r & enables_r);                  // R7
         usb_irq_to_core <= core_irq_en_r && |(flags_r & enables_r); // R13
         endpoint_index  <= sel;                                     // R10
      end
   end
endmodule : ugi_top

// file: hw/ugi_pkg.sv
// Purpose: shared constants and carriers for the usb global interrupt and endpoint select block
// Assumes: apb with 32-bit data, 8-bit registers in the low byte of each word
// Notes: printed offsets are not multiples of four, so they are register indices
package ugi_pkg;

   localparam int          ADDR_W           = 12;
   localparam int          NUM_EP           = 4;
   localparam int          EP_IDX_W         = 2;

   // register indices; byte address is index * 4
   localparam logic [9:0]  IDX_EVENT_FLAGS  = 10'h0bd;
   localparam logic [9:0]  IDX_EVENT_ENA    = 10'h0be;
   localparam logic [9:0]  IDX_EP_SELECT    = 10'h0c7;
   localparam logic [9:0]  IDX_EP_CONTROL   = 10'h0d4;
   localparam logic [9:0]  IDX_CORE_IRQ     = 10'h0e8;

   // bit positions
   localparam int          BIT_SUSPEND      = 0;
   localparam int          BIT_FRAME        = 3;
   localparam int          BIT_END_RESET    = 4;
   localparam int          BIT_WAKE_CPU     = 5;
   localparam int          BIT_EP_ON        = 7;
   localparam int          BIT_TOGGLE       = 3;
   localparam int          BIT_CORE_IRQ_EN  = 0;

   localparam logic [7:0]  FLAG_MASK        = 8'h39;
   localparam logic [7:0]  EP_SEL_MASK      = 8'h03;
   localparam logic [7:0]  EP_CTRL_WR_MASK  = 8'h87;
   localparam logic [7:0]  FLAGS_RESET      = 8'h00;
   localparam logic [7:0]  ENA_RESET        = 8'h10;
   localparam logic [7:0]  EP_SEL_RESET     = 8'h00;
   localparam logic [7:0]  EP_CTRL_RESET    = 8'h00;

   // suspend timing: three frame periods of idle j state
   localparam int          CLK_HZ           = 20_000_000;
   localparam int          SUSPEND_IDLE_MS  = 3;
   localparam int          SUSPEND_CYCLES   = CLK_HZ / 1000 * SUSPEND_IDLE_MS;

   // bus-side event pulses from the serial engine
   typedef struct packed {
      logic frame_ok;
      logic reset_end;
      logic non_idle;
      logic upstream_resume;
      logic data1_rx;
      logic data0_rx;
   } ugi_evt_s;

endpackage : ugi_pkg

// file: hw/ugi_suspend_det.sv
// Purpose: detects bus suspend after a long idle j state
// Assumes: idle_j is already synchronised to pclk
// Notes: fires once per idle stretch; non-idle restarts the count
`timescale 1ns/1ps
module ugi_suspend_det #(
   parameter int IDLE_CYCLES = 60000
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic idle_j,
   output logic      suspend_pulse,
   output logic      suspended
);
   logic [31:0] cnt_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r         <= 32'h0;
         suspend_pulse <= 1'b0;
         suspended     <= 1'b0;
      end else begin
         suspend_pulse <= 1'b0;
         if (!idle_j) begin
            cnt_r     <= 32'h0;
            suspended <= 1'b0;
         end else if (!suspended) begin
            if (cnt_r == 32'(IDLE_CYCLES - 1)) begin
               suspend_pulse <= 1'b1;
               suspended     <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 32'h1;
            end
         end
      end
   end
endmodule : ugi_suspend_det

// file: hw/ugi_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are slow levels from outside the pclk domain
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module ugi_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : ugi_sync

// file: dv/ugi_checker.sv
// Purpose: port checks for ugi_top
// Assumes: one pclk domain, presetn async low
// Notes: flags are not ports, so stickiness is seen through usb_irq
`timescale 1ns/1ps
module ugi_checker
   import ugi_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              usb_irq,
   input wire logic              usb_irq_to_core
);
   localparam logic [11:0] A_FLG = {IDX_EVENT_FLAGS, 2'b00};
   localparam logic [11:0] A_ENA = {IDX_EVENT_ENA, 2'b00};
   localparam logic [11:0] A_SEL = {IDX_EP_SELECT, 2'b00};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_cause: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   a_err_misalign: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr)
      else $error("misaligned access not refused");
   a_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_flag_rsvd: assert property (pready && !pwrite && paddr == A_FLG |-> (prdata[7:0] & 8'hc6) == 8'h0)
      else $error("reserved flag bits set");
   a_ena_rsvd: assert property (pready && !pwrite && paddr == A_ENA |-> (prdata[7:0] & 8'hc6) == 8'h0)
      else $error("reserved enable bits set");
   a_sel_rsvd: assert property (pready && !pwrite && paddr == A_SEL |-> prdata[7:2] == 6'h0)
      else $error("reserved index bits set");
   a_core_gate: assert property (usb_irq_to_core |-> usb_irq)
      else $error("core irq without usb irq");
   // no write one edge back means flags and enables could only gain bits
   a_irq_sticky: assert property (usb_irq && $past(!(psel && penable && pwrite)) |=> usb_irq)
      else $error("irq dropped without a write");
endmodule : ugi_checker

bind ugi_top ugi_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .usb_irq, .usb_irq_to_core);

// file: dv/ugi_host_model.sv
// Purpose: usb host side as seen by the serial engine outputs
// Assumes: events are one-cycle pulses on pclk
// Notes: resume ends the idle stretch, as a real host would
`timescale 1ns/1ps
module ugi_host_model
   import ugi_pkg::*;
(
   input wire logic              pclk,
   output ugi_pkg::ugi_evt_s     evt,
   output logic                  bus_idle_j,
   output logic [EP_IDX_W-1:0]   rx_ep
);
   initial begin
      evt = '0;
      bus_idle_j = 1'b0;
      rx_ep = '0;
   end
   task automatic send(input logic [5:0] e, input logic [EP_IDX_W-1:0] ep);
      @(posedge pclk);
      evt <= e;
      rx_ep <= ep;
      @(posedge pclk);
      evt <= '0;
   endtask : send
   task automatic idle(input int n);
      @(posedge pclk);
      bus_idle_j <= 1'b1;
      repeat (n) @(posedge pclk);
   endtask : idle
   // own resume marks the wake as the device's doing
   task automatic wake(input logic own);
      send({3'b001, own, 2'b00}, '0);
      bus_idle_j <= 1'b0;
   endtask : wake
endmodule : ugi_host_model

// file: dv/tb.sv
// Purpose: register and event scenarios for ugi_top
// Assumes: apb slave answers with one access cycle
// Notes: suspend count shortened to keep the run brief
`timescale 1ns/1ps
module tb;
   import ugi_pkg::*;
   localparam int          SUSP  = 20;
   localparam logic [11:0] A_FLG = {IDX_EVENT_FLAGS, 2'b00};
   localparam logic [11:0] A_ENA = {IDX_EVENT_ENA, 2'b00};
   localparam logic [11:0] A_SEL = {IDX_EP_SELECT, 2'b00};
   localparam logic [11:0] A_CTL = {IDX_EP_CONTROL, 2'b00};
   localparam logic [11:0] A_COR = {IDX_CORE_IRQ, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        usb_irq, usb_irq_to_core, bus_idle_j;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  pstrb, endpoint_on;
   logic [1:0]  rx_ep, endpoint_index;
   ugi_evt_s    evt;
   int          fails, n_compared;
   ugi_top #(.SUSPEND_IDLE_CYCLES(SUSP)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .bus_idle_j, .evt, .rx_ep, .usb_irq, .usb_irq_to_core,
      .endpoint_on, .endpoint_index);
   ugi_host_model host (.pclk, .evt, .bus_idle_j, .rx_ep);
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      // a hung slave ends the run here
      if (pready !== 1'b1) begin
         fails++;
         tally_and_finish();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), {24'h0, e}, q);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      fails = 0;
      n_compared = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_FLG, 8'h00);
      rd(A_ENA, 8'h10);
      rd(A_SEL, 8'h00);
      wr(A_ENA, 8'hff);
      rd(A_ENA, 8'h39);
      wr(A_SEL, 8'hff);
      rd(A_SEL, 8'h03);
      chk("endpoint_index", 32'h3, {30'h0, endpoint_index});
      wr(A_CTL, 8'h87);
      rd(A_CTL, 8'h87);
      wr(A_SEL, 8'h00);
      wr(A_CTL, 8'h80);
      repeat (2) @(posedge pclk);
      chk("endpoint_on", 32'h9, {28'h0, endpoint_on});
      host.send(6'h02, 2'd0);
      rd(A_CTL, 8'h88);
      host.send(6'h01, 2'd0);
      rd(A_CTL, 8'h80);
      apb(1'b0, 12'h004, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
      host.send(6'h20, 2'd0);
      rd(A_FLG, 8'h08);
      apb(1'b0, A_FLG + 12'h001, 32'h0);
      chk("pslverr_misaligned", 32'h1, {31'h0, err});
      chk("prdata_misaligned", 32'h0, q);
      chk("usb_irq", 32'h1, {31'h0, usb_irq});
      chk("irq_to_core", 32'h0, {31'h0, usb_irq_to_core});
      wr(A_COR, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq_to_core", 32'h1, {31'h0, usb_irq_to_core});
      wr(A_ENA, 8'h31);
      repeat (2) @(posedge pclk);
      chk("usb_irq", 32'h0, {31'h0, usb_irq});
      wr(A_FLG, 8'hff);
      rd(A_FLG, 8'h08);
      wr(A_FLG, 8'h00);
      rd(A_FLG, 8'h00);
      host.send(6'h10, 2'd0);
      rd(A_FLG, 8'h10);
      host.send(6'h08, 2'd0);
      rd(A_FLG, 8'h10);
      host.idle(SUSP + 4);
      rd(A_FLG, 8'h11);
      host.wake(1'b1);
      rd(A_FLG, 8'h11);
      host.idle(SUSP + 4);
      host.wake(1'b0);
      rd(A_FLG, 8'h31);
      chk("usb_irq", 32'h1, {31'h0, usb_irq});
      wr(A_FLG, 8'h1f);
      rd(A_FLG, 8'h11);
      tally_and_finish();
   end
endmodule : tb
